// ### rtl/hub_lock_pkg.sv
// Constants and carrier types shared by the hub lock pool and its core ports
package hub_lock_pkg;

  // Pool and core counts
  localparam int LOCK_COUNT    = 8;
  localparam int LOCK_ID_W     = 3;
  localparam int CORE_COUNT    = 8;
  localparam int CORE_IDX_W    = 3;

  // Hub operation field, lock codes occupy the upper half
  localparam int HUB_OP_W      = 3;
  localparam logic [HUB_OP_W-1:0] allocate_lock_op = 3'h4;
  localparam logic [HUB_OP_W-1:0] release_lock_op  = 3'h5;
  localparam logic [HUB_OP_W-1:0] set_lock_op      = 3'h6;
  localparam logic [HUB_OP_W-1:0] clear_lock_op    = 3'h7;

  // Hub timing in clocks
  localparam int HUB_SLOT_CLKS = 2;
  localparam int SLOT_PH_W     = 1;
  localparam int HUB_MIN_CLKS  = 7;
  localparam int HUB_MAX_CLKS  = 22;
  localparam int FIN_CLKS      = HUB_MIN_CLKS - 1;
  localparam int FIN_CNT_W     = 3;

  // Reset values
  localparam logic [LOCK_COUNT-1:0] LOCK_STATE_RST = 8'h00;
  localparam logic [LOCK_COUNT-1:0] LOCK_ALLOC_RST = 8'h00;

  // One hub lock request from a core
  typedef struct packed {
    logic                 valid;
    logic [HUB_OP_W-1:0]  op;
    logic [LOCK_ID_W-1:0] id;
    logic                 write_carry_effect;
    logic                 write_zero_effect;
    logic                 no_result_write_effect;
  } core_req_t;

  // Outcome of one lock operation
  typedef struct packed {
    logic                 carry;
    logic                 carry_we;
    logic                 zero;
    logic                 zero_we;
    logic [LOCK_ID_W-1:0] result;
    logic                 result_we;
  } lock_res_t;

  // Answer to a core
  typedef struct packed {
    logic      busy;
    logic      done;
    lock_res_t res;
  } core_rsp_t;

  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_FIN} port_state_t;

endpackage

// ### rtl/hub_lock_port.sv
// Per-core request holder: waits for the hub slot, then counts out the fixed tail
`timescale 1ns/1ps
`default_nettype none
module hub_lock_port #(
  parameter int FIN_CLKS_P = hub_lock_pkg::FIN_CLKS
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  // Core side
  input  wire hub_lock_pkg::core_req_t req,
  output var  hub_lock_pkg::core_rsp_t rsp,
  // Pool side
  input  wire logic                   grant,
  input  wire hub_lock_pkg::lock_res_t res,
  output logic                        pend,
  output var  hub_lock_pkg::core_req_t preq
);
  import hub_lock_pkg::*;

  typedef struct packed {
    port_state_t          st;
    logic [FIN_CNT_W-1:0] cnt;
    core_req_t            req;
    core_rsp_t            rsp;
  } port_st_t;

  port_st_t s_r;
  port_st_t s_nxt;

  // Counter must hold the tail length
  if (FIN_CLKS_P < 1 || FIN_CLKS_P > (1 << FIN_CNT_W))
  begin : g_bad_fin
    $error("FIN_CLKS_P out of range");
  end

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.done = 1'b0;
    unique case (s_r.st)
      PS_IDLE:
      begin
        // Only the lock codes of the hub operation field are taken here
        if (req.valid && req.op[HUB_OP_W-1])
        begin
          s_nxt.req      = req;
          s_nxt.st       = PS_WAIT;
          s_nxt.rsp.busy = 1'b1;
        end
      end
      PS_WAIT:
      begin
        // Access happens only in this core's own hub slot
        if (grant)
        begin
          s_nxt.rsp.res = res;
          s_nxt.cnt     = FIN_CNT_W'(FIN_CLKS_P - 1);
          s_nxt.st      = PS_FIN;
        end
      end
      PS_FIN:
      begin
        if (s_r.cnt == '0)
        begin
          s_nxt.rsp.done = 1'b1;
          s_nxt.rsp.busy = 1'b0;
          s_nxt.st       = PS_IDLE;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{st: PS_IDLE, cnt: '0, req: '0, rsp: '0};
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign rsp  = s_r.rsp;
  assign preq = s_r.req;
  assign pend = (s_r.st == PS_WAIT);

endmodule
`default_nettype wire

// ### rtl/hub_lock_semaphore_pool.sv
// Shared pool of eight hub locks served to the cores in rotating hub slots
`timescale 1ns/1ps
`default_nettype none
module hub_lock_semaphore_pool #(
  parameter int NUM_CORES = hub_lock_pkg::CORE_COUNT
) (
  // Clock, reset and freeze
  input  wire logic                                  ref_clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  ce,
  // Core requests and answers
  input  wire hub_lock_pkg::core_req_t [NUM_CORES-1:0] core_req,
  output var  hub_lock_pkg::core_rsp_t [NUM_CORES-1:0] core_rsp,
  // Pool observation
  output logic [hub_lock_pkg::LOCK_COUNT-1:0]        lock_state,
  output logic [hub_lock_pkg::LOCK_COUNT-1:0]        lock_alloc
);
  import hub_lock_pkg::*;

  typedef struct packed {
    logic [CORE_IDX_W-1:0] slot;
    logic [SLOT_PH_W-1:0]  phase;
    logic [LOCK_COUNT-1:0] locks;
    logic [LOCK_COUNT-1:0] alloc;
  } pool_st_t;

  pool_st_t              s_r;
  pool_st_t              s_nxt;
  logic [NUM_CORES-1:0]  grant;
  logic [NUM_CORES-1:0]  pend;
  core_req_t [NUM_CORES-1:0] preq;
  lock_res_t             res;
  logic                  exec;
  core_req_t             ex_req;
  logic [LOCK_ID_W-1:0]  ex_id;
  logic [CORE_IDX_W-1:0] gi;
  logic                  free_found;
  logic [LOCK_ID_W-1:0]  free_id;

  // The slot rotation must span exactly the documented latency spread
  if (NUM_CORES < 1 || NUM_CORES > (1 << CORE_IDX_W) ||
      NUM_CORES * HUB_SLOT_CLKS != HUB_MAX_CLKS - HUB_MIN_CLKS + 1)
  begin : g_bad_cores
    $error("NUM_CORES does not fit the hub slot rotation");
  end

  // One port sequencer per core
  for (genvar c = 0; c < NUM_CORES; c++)
  begin : g_port
    assign grant[c] = (s_r.slot == CORE_IDX_W'(c)) && (s_r.phase == '0);
    hub_lock_port #(
      .FIN_CLKS_P (FIN_CLKS)
    ) u_port (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .req     (core_req[c]),
      .rsp     (core_rsp[c]),
      .grant   (grant[c]),
      .res     (res),
      .pend    (pend[c]),
      .preq    (preq[c])
    );
  end

  // Granted core; only one core can touch the pool per cycle, so no arbitration
  assign gi     = s_r.slot;
  assign exec   = (s_r.phase == '0) && pend[gi];
  assign ex_req = preq[gi];
  assign ex_id  = ex_req.id;

  // Lowest numbered free lock
  always_comb
  begin
    free_found = 1'b0;
    free_id    = '0;
    for (int i = LOCK_COUNT - 1; i >= 0; i--)
    begin
      if (!s_r.alloc[i])
      begin
        free_found = 1'b1;
        free_id    = LOCK_ID_W'(i);
      end
    end
  end

  // Slot rotation and lock operations
  always_comb
  begin
    s_nxt = s_r;
    res   = '0;
    if (s_r.phase == SLOT_PH_W'(HUB_SLOT_CLKS - 1))
    begin
      s_nxt.phase = '0;
      s_nxt.slot  = (s_r.slot == CORE_IDX_W'(NUM_CORES - 1)) ? '0 : s_r.slot + 1'b1;
    end
    else
    begin
      s_nxt.phase = s_r.phase + 1'b1;
    end
    if (exec)
    begin
      unique case (ex_req.op)
        allocate_lock_op:
        begin
          res.carry_we = ex_req.write_carry_effect;
          res.zero_we  = ex_req.write_zero_effect;
          if (free_found)
          begin
            s_nxt.alloc[free_id] = 1'b1;
            res.result    = free_id;
            res.result_we = !ex_req.no_result_write_effect;
            res.zero      = (free_id == '0);
          end
          else
          begin
            // Nothing handed out, destination left alone
            res.carry = 1'b1;
          end
        end
        release_lock_op:
        begin
          s_nxt.alloc[ex_id] = 1'b0;
        end
        set_lock_op:
        begin
          res.carry          = s_r.locks[ex_id];
          res.carry_we       = ex_req.write_carry_effect;
          s_nxt.locks[ex_id] = 1'b1;
        end
        clear_lock_op:
        begin
          res.carry          = s_r.locks[ex_id];
          res.carry_we       = ex_req.write_carry_effect;
          s_nxt.locks[ex_id] = 1'b0;
        end
        default:
        begin
          res = '0;
        end
      endcase
    end
  end

  // Pool register; reset frees every lock
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{slot: '0, phase: '0, locks: LOCK_STATE_RST, alloc: LOCK_ALLOC_RST};
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign lock_state = s_r.locks;
  assign lock_alloc = s_r.alloc;

  // Helper: has any allocate run since reset
  logic seen_alloc_r;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seen_alloc_r <= 1'b0;
    end
    else if (ce && exec && ex_req.op == allocate_lock_op)
    begin
      seen_alloc_r <= 1'b1;
    end
  end

  // Checks count only enabled edges, so a frozen block stretches no latency
  // Done is registered, so it is sampled one edge after the completing edge
  localparam int lat_lo = HUB_MIN_CLKS + 1;
  localparam int lat_hi = HUB_MAX_CLKS + 1;
  logic taken0;
  assign taken0 = core_req[0].valid && core_req[0].op[HUB_OP_W-1] && !core_rsp[0].busy;

  default clocking dc @(posedge ref_clk iff ce);
  endclocking
  default disable iff (!arst_n);

  a_clear_forces_zero: assert property ((exec && ex_req.op == clear_lock_op) |=>
    !s_r.locks[$past(ex_id)]) else $error("clear left lock set");
  a_clear_prior_carry: assert property ((exec && ex_req.op == clear_lock_op) |=>
    core_rsp[$past(gi)].res.carry == $past(s_r.locks[ex_id])) else $error("clear carry wrong");
  a_set_forces_one: assert property ((exec && ex_req.op == set_lock_op) |=>
    s_r.locks[$past(ex_id)] && core_rsp[$past(gi)].res.carry == $past(s_r.locks[ex_id]))
    else $error("set failed or carry wrong");
  a_alloc_one_more: assert property ((exec && ex_req.op == allocate_lock_op && free_found) |=>
    $countones(s_r.alloc) == $countones($past(s_r.alloc)) + 1) else $error("allocate count");
  a_alloc_full_carry: assert property ((exec && ex_req.op == allocate_lock_op && !free_found
    && ex_req.write_carry_effect) |=> core_rsp[$past(gi)].res.carry && s_r.alloc == '1)
    else $error("full pool not reported");
  a_alloc_zero_flag: assert property ((exec && ex_req.op == allocate_lock_op && free_found
    && ex_req.write_zero_effect) |=> core_rsp[$past(gi)].res.zero_we &&
    core_rsp[$past(gi)].res.zero == (core_rsp[$past(gi)].res.result == '0))
    else $error("zero flag wrong");
  a_release_frees: assert property ((exec && ex_req.op == release_lock_op) |=>
    !s_r.alloc[$past(ex_id)]) else $error("release kept lock");
  a_lat_not_early: assert property (taken0 |=> (!core_rsp[0].done && core_rsp[0].busy)[*7])
    else $error("done too early");
  a_lat_upper_bound: assert property (taken0 |-> ##[lat_lo:lat_hi] core_rsp[0].done)
    else $error("done not within window");
  a_reset_all_free: assert property (!seen_alloc_r |-> s_r.alloc == '0)
    else $error("lock allocated without allocate");

  c_alloc_zero: cover property (exec && ex_req.op == allocate_lock_op && free_id == '0);
  c_pool_full: cover property (exec && ex_req.op == allocate_lock_op && !free_found);
  c_set_when_set: cover property (exec && ex_req.op == set_lock_op && s_r.locks[ex_id]);
  c_lat_longest: cover property (taken0 ##23 core_rsp[0].done);

endmodule
`default_nettype wire

// ### verification/hub_core_model.sv
// Behavioural core that issues hub lock operations and stalls until they finish
`timescale 1ns/1ps
`default_nettype none
module hub_core_model (
  // Clock
  input  wire logic                    ref_clk,
  // Hub port
  input  wire hub_lock_pkg::core_rsp_t rsp,
  output var  hub_lock_pkg::core_req_t req
);
  import hub_lock_pkg::*;

  // Idle core presents no request from time zero
  initial req = '0;

  // Present, withdraw after the take edge, then stall until done
  task automatic run(input logic [2:0] op, input logic [2:0] id, input logic [2:0] eff,
                     output int lat, output lock_res_t res);
    lat = 0;
    @(posedge ref_clk);
    #2;
    req = {1'b1, op, id, eff};
    @(posedge ref_clk);
    #2;
    // Fields turned over so a stale request is never mistaken for a live one
    req = {1'b0, ~op, ~id, ~eff};
    lat = 0;  // The take edge is edge 0
    while (rsp.done !== 1'b1 && lat < 40)
    begin
      @(posedge ref_clk);
      #2;
      lat++;
    end
    res = rsp.res;
  endtask
endmodule
`default_nettype wire

// ### verification/hub_lock_semaphore_pool_test.sv
// Self-checking bench for the hub lock pool driven by two core models
`timescale 1ns/1ps
`default_nettype none
module hub_lock_semaphore_pool_test;
  import hub_lock_pkg::*;

  // Clock, reset and core wiring
  logic                  ref_clk;
  logic                  arst_n;
  logic                  ce;
  core_req_t             req0;
  core_req_t             req1;
  wire core_req_t [7:0]  core_req;
  core_rsp_t [7:0]       core_rsp;
  logic [LOCK_COUNT-1:0] lock_state;
  logic [LOCK_COUNT-1:0] lock_alloc;
  int                    n_mismatch;
  int                    comparisons;

  // Only cores 0 and 1 are modelled; idle cores still take their slots
  assign core_req = {60'h0, req1, req0};

  hub_lock_semaphore_pool #(.NUM_CORES(8)) i_dut (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .ce         (ce),
    .core_req   (core_req),
    .core_rsp   (core_rsp),
    .lock_state (lock_state),
    .lock_alloc (lock_alloc)
  );
  hub_core_model i_core0 (.ref_clk(ref_clk), .rsp(core_rsp[0]), .req(req0));
  hub_core_model i_core1 (.ref_clk(ref_clk), .rsp(core_rsp[1]), .req(req1));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // Count and report one comparison
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print counts and the verdict, then stop
  task automatic report_and_stop();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One operation on a chosen core, latency judged every time
  task automatic do_op(input bit core, input logic [2:0] op, input logic [2:0] id,
                       input logic [2:0] eff, output lock_res_t r);
    int lat;
    if (core)
      i_core1.run(op, id, eff, lat, r);
    else
      i_core0.run(op, id, eff, lat, r);
    check("latency", 8'(lat >= 7 && lat <= 22), 8'h01);
  endtask

  // Fill the pool, then ask once more
  task automatic test_alloc_all();
    lock_res_t r;
    check("state at reset", lock_state, 8'h00);
    check("alloc at reset", lock_alloc, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      do_op(1'b0, allocate_lock_op, 3'h0, 3'b110, r);
      check("alloc id", 8'(r.result), 8'(i));
      check("alloc write", 8'(r.result_we), 8'h01);
      check("alloc zero", 8'({r.zero, r.zero_we}), (i == 0) ? 8'h03 : 8'h01);
      check("alloc carry", 8'({r.carry, r.carry_we}), 8'h01);
    end
    do_op(1'b1, allocate_lock_op, 3'h0, 3'b110, r);
    check("full carry", 8'({r.carry, r.carry_we}), 8'h03);
    check("full write", 8'(r.result_we), 8'h00);
    check("alloc map", lock_alloc, 8'hff);
  endtask

  // Release two locks, then two cores race to take them back
  task automatic test_release();
    lock_res_t ra;
    lock_res_t rb;
    do_op(1'b1, release_lock_op, 3'h3, 3'b000, ra);
    do_op(1'b1, release_lock_op, 3'h6, 3'b000, ra);
    check("after release", lock_alloc, 8'hb7);
    fork
      do_op(1'b0, allocate_lock_op, 3'h0, 3'b100, ra);
      do_op(1'b1, allocate_lock_op, 3'h0, 3'b001, rb);
    join
    check("distinct ids", 8'(ra.result ^ rb.result), 8'h05);
    check("suppressed write", 8'(rb.result_we), 8'h00);
    check("realloc map", lock_alloc, 8'hff);
  endtask

  // Set twice then clear twice, watching the prior state each time
  task automatic test_set_clear();
    lock_res_t  r;
    logic [2:0] ops [4] = '{set_lock_op, set_lock_op, clear_lock_op, clear_lock_op};
    logic [3:0] prior = 4'b0110;
    for (int i = 0; i < 4; i++)
    begin
      do_op(1'b1, ops[i], 3'h5, 3'b100, r);
      check("prior state", 8'({r.carry, r.carry_we}), 8'({prior[i], 1'b1}));
      check("lock bits", lock_state, ops[i][0] ? 8'h00 : 8'h20);
    end
    do_op(1'b0, set_lock_op, 3'h0, 3'b000, r);
    do_op(1'b1, set_lock_op, 3'h7, 3'b000, r);
    check("no carry write", 8'(r.carry_we), 8'h00);
    check("edge ids", lock_state, 8'h81);
  endtask

  // Reset in mid-run frees the pool and drops every lock
  task automatic test_reset_mid();
    @(posedge ref_clk);
    #2;
    arst_n = 1'b0;
    @(posedge ref_clk);
    #2;
    check("state in reset", lock_state, 8'h00);
    check("alloc in reset", lock_alloc, 8'h00);
    arst_n = 1'b1;
  endtask

  // Freeze for five edges in mid-operation; the wait stretches by as much
  task automatic test_freeze();
    lock_res_t r;
    int        lat;
    fork
      i_core0.run(set_lock_op, 3'h2, 3'b100, lat, r);
      begin
        repeat (3) @(posedge ref_clk);
        #2;
        ce = 1'b0;
        repeat (5) @(posedge ref_clk);
        #2;
        ce = 1'b1;
      end
    join
    check("frozen latency", 8'(lat >= 12 && lat <= 27), 8'h01);
    check("frozen set", 8'({r.carry, r.carry_we}), 8'h01);
    check("frozen lock", lock_state, 8'h04);
  endtask

  // A code outside the lock group is never taken: no busy, no done, no change
  task automatic test_ignored();
    lock_res_t r;
    int        lat;
    i_core0.run(3'h3, 3'h2, 3'b100, lat, r);
    check("ignored op wait", 8'(lat), 8'h28);
    check("ignored busy", 8'(core_rsp[0].busy), 8'h00);
    check("ignored lock", lock_state, 8'h04);
  endtask

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    ref_clk = 1'b0;
    ce = 1'b1;
    arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    arst_n = 1'b1;
    test_alloc_all();
    test_release();
    test_set_clear();
    test_reset_mid();
    test_freeze();
    test_ignored();
    report_and_stop();
  end

  // Watchdog well past the expected run of some 370 clocks
  initial
  begin
    #(3000 * 25);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
